/* File: rtl/mmbc_regs.svh */
// Constants for the minimum-mode bus control and prefetch block
`ifndef MMBC_REGS_SVH
`define MMBC_REGS_SVH

`define MMBC_QUEUE_BYTES 6
`define MMBC_FETCH_ROOM  2
`define MMBC_OPQ_DEPTH   16
`define MMBC_ADDR_W      20

`define MMBC_QS_NOP      2'h0
`define MMBC_QS_FIRST    2'h1
`define MMBC_QS_EMPTY    2'h2
`define MMBC_QS_SUB      2'h3

`endif

/* File: rtl/mmbc_pkg.sv */
// Types shared by the bus control and prefetch block
package mmbc_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_T1   = 6'h02,
    ST_T2   = 6'h04,
    ST_T3   = 6'h08,
    ST_TW   = 6'h10,
    ST_T4   = 6'h20
  } mmbc_state_t;

  typedef enum logic [2:0] {
    CMD_MEM_RD = 3'h0,
    CMD_MEM_WR = 3'h1,
    CMD_IO_RD  = 3'h2,
    CMD_IO_WR  = 3'h3,
    CMD_INT_ACK_STROBE_N   = 3'h4,
    CMD_FETCH  = 3'h5
  } mmbc_cmd_t;

endpackage

/* File: rtl/mmbc_sync.sv */
// Two-stage synchroniser for pin inputs, one chain per bit
`timescale 1ns/1ps
module mmbc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // System clock
  input  wire logic         reset, // Async reset, active high
  input  wire logic [W-1:0] d,     // Raw pin levels
  output logic      [W-1:0] q      // Synchronised levels
);
  logic [W-1:0] meta_r;

  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          meta_r[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          q[i]      <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule

/* File: rtl/mmbc_fifo.sv */
// Parameterised show-ahead FIFO with valid/ready on both sides
`timescale 1ns/1ps
module mmbc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,       // System clock
  input  wire logic         reset,     // Async reset, active high
  input  wire logic         in_valid,  // Writer offers a word
  output logic              in_ready,  // Room for a word
  input  wire logic [W-1:0] in_data,   // Word offered
  output logic              out_valid, // A word is waiting
  input  wire logic         out_ready, // Reader takes the word
  output logic      [W-1:0] out_data   // Oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("mmbc_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];

  always_comb begin
    push    = in_valid && in_ready;
    pop     = out_ready && out_valid;
    wr_nxt  = push ? wr_r + 1'b1 : wr_r;
    rd_nxt  = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage carries no reset; only the pointers and the count need a known value
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
endmodule

/* File: rtl/mmbc_top.sv */
// Minimum-mode bus control and instruction prefetch front end
// Summary of operation
// R1 - Select high memory, low I/O, valid T4-to-T4; code changes select at T1 start
// R2 - Grant floats select, write, direction, enable
// R3 - Write strobe low in T2, T3, waits
// R4 - Acknowledge strobe low in T2, T3, waits
// R5 - Latch pulse high during every T1
// R6 - Latch pulse always driven, even granted
// R7 - Direction high transmit, timed like select
// R8 - Transceiver enable low on every access
// R9 - Read enable from mid-T2 to mid-T4; code enables T3 to T4 start
// R10 - Write enable from T2 start to mid-T4; code closes at T4 start
// R11 - Grant raised mid T4 or idle on request
// R12 - Outputs float when grant rises
// R13 - Drop grant; drive again on next cycle
// R14 - Hold request synchronised before use
// R15 - Prefetch queue holds at most six bytes
// R16 - Fetch word when two bytes free
// R17 - Queue is first-in-first-out, drained on demand
// R18 - First byte into empty queue shows at once
// R19 - Operand addresses relocated by bus side
// R20 - Twenty-bit byte address per access
// R21 - Queue state code reported next clock
// R22 - Four states per cycle, waits after T3
// R23 - Controls driven only in minimum mode; code drives addr_latch in both modes
`timescale 1ns/1ps
`include "mmbc_regs.svh"
module mmbc_top #(
  parameter int QB        = `MMBC_QUEUE_BYTES,
  parameter int OPQ_DEPTH = `MMBC_OPQ_DEPTH
) (
  input  wire logic        clk,              // 20 MHz clock
  input  wire logic        reset,            // Async reset, active high
  input  wire logic        config_strap,     // High selects minimum mode
  input  wire logic        hold_req,         // Alternate master request
  input  wire logic        bus_ready,        // Addressed device ready
  output logic             hold_grant,       // Bus granted away
  output logic             addr_latch,       // Address latch pulse
  output logic             mem_io_sel,       // High memory, low I/O
  output logic             mem_io_sel_oe,    // Drive enable for select
  output logic             write_strobe_n,   // Write strobe
  output logic             write_strobe_oe,  // Drive enable for write
  output logic             int_ack_strobe_n, // Acknowledge read strobe
  output logic             int_ack_oe,       // Drive enable for ack
  output logic             xcvr_direction,   // High transmit, low receive
  output logic             xcvr_dir_oe,      // Drive enable for direction
  output logic             xcvr_enable_n,    // Transceiver enable
  output logic             xcvr_enable_oe,   // Drive enable for enable
  output logic [19:0]      bus_addr,         // Byte address
  output logic             bus_addr_oe,      // Address drive enable
  output logic [15:0]      bus_data_out,     // Write data
  input  wire logic [15:0] bus_data_in,      // Read data pins
  output logic             bus_data_oe,      // Data drive enable
  output logic [1:0]       queue_state,      // Queue activity code
  input  wire logic        flush,            // Branch: empty queue
  input  wire logic [15:0] flush_seg,        // New code segment
  input  wire logic [15:0] flush_off,        // New instruction offset
  output logic [7:0]       q_byte,           // Oldest queued byte
  output logic             q_valid,          // Queue not empty
  input  wire logic        q_take,           // Execution side takes byte
  input  wire logic        q_first,          // Taken byte is an opcode
  input  wire logic        op_valid,         // Operand request offered
  output logic             op_ready,         // Request accepted
  input  wire logic [2:0]  op_cmd,           // Operation code
  input  wire logic [15:0] op_seg,           // Segment base
  input  wire logic [15:0] op_off,           // Unrelocated offset
  input  wire logic [15:0] op_wdata,         // Data to write
  output logic [15:0]      rd_data,          // Data read
  output logic             rd_valid          // Read data pulse
);
  localparam int QW  = $clog2(QB);
  localparam int CW  = $clog2(QB + 1);
  localparam int OPW = 51;

  generate
    if (QB < 2) begin : g_qb_chk
      $error("mmbc_top: QB must be at least 2");
    end
  endgenerate

  // Pin inputs after the two-flop chain
  logic [2:0]    pins_s;
  logic          hold_s;
  logic          ready_s;
  logic          min_s;

  // Bus sequencer state
  mmbc_pkg::mmbc_state_t state_r;
  mmbc_pkg::mmbc_state_t state_nxt;
  mmbc_pkg::mmbc_cmd_t   cmd_r;
  mmbc_pkg::mmbc_cmd_t   cmd_nxt;
  logic          granted_r;
  logic          granted_nxt;
  logic          drive_r;
  logic          drive_nxt;
  logic          stale_r;
  logic          stale_nxt;
  logic [19:0]   addr_r;
  logic [19:0]   addr_nxt;
  logic [15:0]   wdata_r;
  logic [15:0]   wdata_nxt;
  logic [15:0]   seg_r;
  logic [15:0]   seg_nxt;
  logic [15:0]   ip_r;
  logic [15:0]   ip_nxt;
  logic [15:0]   rdat_r;
  logic [15:0]   rdat_nxt;
  logic          rvld_r;
  logic          rvld_nxt;
  logic          starting;
  logic          fetch_ok;
  logic          done;

  // Registered pin outputs
  logic          ale_r;
  logic          ale_nxt;
  logic          sel_r;
  logic          sel_nxt;
  logic          dir_r;
  logic          dir_nxt;
  logic          wr_n_r;
  logic          wr_n_nxt;
  logic          ack_n_r;
  logic          ack_n_nxt;
  logic          en_n_r;
  logic          en_n_nxt;
  logic          oe_r;
  logic          oe_nxt;
  logic          doe_r;
  logic          doe_nxt;
  logic          wr_cyc;
  logic          mid_ph;
  logic          late_ph;

  // Prefetch queue
  logic [7:0]    qmem [QB];
  logic [QW-1:0] head_r;
  logic [QW-1:0] head_nxt;
  logic [QW-1:0] tail_r;
  logic [QW-1:0] tail_nxt;
  logic [QW-1:0] tail_p1;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [1:0]    qs_r;
  logic [1:0]    qs_nxt;
  logic          push;
  logic          pop;
  logic [QB-1:0] wr_lo;
  logic [QB-1:0] wr_hi;

  // Operand request queue
  logic             opq_valid;
  logic             opq_pop;
  logic [OPW-1:0]   opq_data;
  mmbc_pkg::mmbc_cmd_t opq_cmd;
  logic [15:0]      opq_seg;
  logic [15:0]      opq_off;
  logic [15:0]      opq_wdata;

  function automatic logic [QW-1:0] q_inc(input logic [QW-1:0] p);
    q_inc = (p == QW'(QB - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic [19:0] reloc(input logic [15:0] s,
                                        input logic [15:0] o);
    reloc = {s, 4'h0} + {4'h0, o};
  endfunction

  function automatic logic is_wr(input mmbc_pkg::mmbc_cmd_t c);
    is_wr = (c == mmbc_pkg::CMD_MEM_WR) || (c == mmbc_pkg::CMD_IO_WR);
  endfunction

  function automatic logic is_mem(input mmbc_pkg::mmbc_cmd_t c);
    is_mem = (c == mmbc_pkg::CMD_MEM_RD) || (c == mmbc_pkg::CMD_MEM_WR) ||
             (c == mmbc_pkg::CMD_FETCH);
  endfunction

  // Request, ready and strap all arrive from other boards
  mmbc_sync #(
    .W (3)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({config_strap, bus_ready, hold_req}),
    .q     (pins_s)
  );

  assign hold_s  = pins_s[0];
  assign ready_s = pins_s[1];
  assign min_s   = pins_s[2];

  mmbc_fifo #(
    .W     (OPW),
    .DEPTH (OPQ_DEPTH)
  ) u_opq (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (op_valid),
    .in_ready  (op_ready),
    .in_data   ({op_cmd, op_seg, op_off, op_wdata}),
    .out_valid (opq_valid),
    .out_ready (opq_pop),
    .out_data  (opq_data)
  );

  assign opq_cmd   = mmbc_pkg::mmbc_cmd_t'(opq_data[50:48]);
  assign opq_seg   = opq_data[47:32];
  assign opq_off   = opq_data[31:16];
  assign opq_wdata = opq_data[15:0];

  // Sequencer: grant first, then operands, then prefetch
  always_comb begin
    state_nxt   = state_r;
    cmd_nxt     = cmd_r;
    granted_nxt = granted_r;
    drive_nxt   = drive_r;
    stale_nxt   = stale_r;
    addr_nxt    = addr_r;
    wdata_nxt   = wdata_r;
    seg_nxt     = seg_r;
    ip_nxt      = ip_r;
    rdat_nxt    = rdat_r;
    rvld_nxt    = 1'b0;
    opq_pop     = 1'b0;
    push        = 1'b0;
    starting    = 1'b0;
    fetch_ok    = !flush && (cnt_r <= CW'(QB - `MMBC_FETCH_ROOM)); // see R16
    done        = ((state_r == mmbc_pkg::ST_T3) ||
                   (state_r == mmbc_pkg::ST_TW)) && ready_s;
    case (state_r)
      mmbc_pkg::ST_IDLE, mmbc_pkg::ST_T4: begin
        state_nxt = mmbc_pkg::ST_IDLE;
        if (granted_r) begin
          if (!hold_s) begin
            granted_nxt = 1'b0; // see R13
          end
        end else if (hold_s) begin
          granted_nxt = 1'b1; // see R11
          drive_nxt   = 1'b0; // see R12
        end else if (opq_valid) begin
          state_nxt = mmbc_pkg::ST_T1;
          cmd_nxt   = opq_cmd;
          addr_nxt  = reloc(opq_seg, opq_off); // see R19 R20
          wdata_nxt = opq_wdata;
          opq_pop   = 1'b1;
          starting  = 1'b1;
        end else if (fetch_ok) begin
          state_nxt = mmbc_pkg::ST_T1;
          cmd_nxt   = mmbc_pkg::CMD_FETCH;
          addr_nxt  = reloc(seg_r, ip_r);
          ip_nxt    = ip_r + 16'h0002;
          stale_nxt = 1'b0;
          starting  = 1'b1;
        end
      end
      mmbc_pkg::ST_T1: begin
        state_nxt = mmbc_pkg::ST_T2;
      end
      mmbc_pkg::ST_T2: begin
        state_nxt = mmbc_pkg::ST_T3;
      end
      mmbc_pkg::ST_T3, mmbc_pkg::ST_TW: begin
        state_nxt = ready_s ? mmbc_pkg::ST_T4 : mmbc_pkg::ST_TW; // see R22
      end
      default: begin
        state_nxt = mmbc_pkg::ST_IDLE;
      end
    endcase
    // Lines are taken back only when a cycle really starts
    if (starting) begin
      drive_nxt = 1'b1; // see R13
    end
    if (done) begin
      if (cmd_r == mmbc_pkg::CMD_FETCH) begin
        push = !stale_r && !flush;
      end else if (!is_wr(cmd_r)) begin
        rdat_nxt = bus_data_in;
        rvld_nxt = 1'b1;
      end
    end
    // A fetch in flight during a flush belongs to the old stream
    if (flush) begin
      seg_nxt = flush_seg;
      ip_nxt  = flush_off;
      if (state_r != mmbc_pkg::ST_IDLE) begin
        stale_nxt = 1'b1;
      end
    end
  end

  // Queue pointers; odd start offsets are not split into a byte fetch
  always_comb begin
    pop      = q_take && (cnt_r != '0); // see R17
    tail_p1  = q_inc(tail_r);
    head_nxt = pop ? q_inc(head_r) : head_r;
    tail_nxt = push ? q_inc(tail_p1) : tail_r;
    cnt_nxt  = cnt_r + (push ? CW'(2) : CW'(0)) - (pop ? CW'(1) : CW'(0));
    qs_nxt   = `MMBC_QS_NOP;
    if (pop) begin
      qs_nxt = q_first ? `MMBC_QS_FIRST : `MMBC_QS_SUB; // see R21
    end
    if (flush) begin
      head_nxt = '0;
      tail_nxt = '0;
      cnt_nxt  = '0;
      qs_nxt   = `MMBC_QS_EMPTY;
    end
  end

  generate
    for (genvar i = 0; i < QB; i++) begin : g_entry
      assign wr_lo[i] = push && (tail_r == QW'(i));
      assign wr_hi[i] = push && (tail_p1 == QW'(i));
    end
  endgenerate

  // Storage needs no reset; the count says what is valid
  always_ff @(posedge clk) begin
    for (int i = 0; i < QB; i++) begin
      if (wr_lo[i]) begin
        qmem[i] <= bus_data_in[7:0];
      end else if (wr_hi[i]) begin
        qmem[i] <= bus_data_in[15:8];
      end
    end
  end

  // Outputs follow the next state so they change with it.
  // Whole-clock resolution: the enable opens at T3 for reads and
  // closes at T4 start, a half clock late at the start and a half clock early at the end.
  always_comb begin
    wr_cyc    = is_wr(cmd_nxt);
    mid_ph    = (state_nxt == mmbc_pkg::ST_T2) ||
                (state_nxt == mmbc_pkg::ST_T3) ||
                (state_nxt == mmbc_pkg::ST_TW);
    late_ph   = (state_nxt == mmbc_pkg::ST_T3) ||
                (state_nxt == mmbc_pkg::ST_TW);
    ale_nxt   = (state_nxt == mmbc_pkg::ST_T1); // see R5 R6
    sel_nxt   = is_mem(cmd_nxt); // see R1
    dir_nxt   = wr_cyc; // see R7
    wr_n_nxt  = !(wr_cyc && mid_ph); // see R3
    ack_n_nxt = !((cmd_nxt == mmbc_pkg::CMD_INT_ACK_STROBE_N) && mid_ph); // see R4
    en_n_nxt  = !(wr_cyc ? mid_ph : late_ph); // see R8 R9 R10
    oe_nxt    = drive_nxt && min_s; // see R2 R23
    doe_nxt   = drive_nxt && wr_cyc && mid_ph;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r   <= mmbc_pkg::ST_IDLE;
      cmd_r     <= mmbc_pkg::CMD_FETCH;
      granted_r <= 1'b0;
      drive_r   <= 1'b1;
      stale_r   <= 1'b0;
      addr_r    <= 20'h00000;
      wdata_r   <= 16'h0000;
      seg_r     <= 16'h0000;
      ip_r      <= 16'h0000;
      rdat_r    <= 16'h0000;
      rvld_r    <= 1'b0;
      head_r    <= '0;
      tail_r    <= '0;
      cnt_r     <= '0;
      qs_r      <= `MMBC_QS_NOP;
      ale_r     <= 1'b0;
      sel_r     <= 1'b0;
      dir_r     <= 1'b0;
      wr_n_r    <= 1'b1;
      ack_n_r   <= 1'b1;
      en_n_r    <= 1'b1;
      oe_r      <= 1'b0;
      doe_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cmd_r     <= cmd_nxt;
      granted_r <= granted_nxt;
      drive_r   <= drive_nxt;
      stale_r   <= stale_nxt;
      addr_r    <= addr_nxt;
      wdata_r   <= wdata_nxt;
      seg_r     <= seg_nxt;
      ip_r      <= ip_nxt;
      rdat_r    <= rdat_nxt;
      rvld_r    <= rvld_nxt;
      head_r    <= head_nxt;
      tail_r    <= tail_nxt;
      cnt_r     <= cnt_nxt;
      qs_r      <= qs_nxt;
      ale_r     <= ale_nxt;
      sel_r     <= sel_nxt;
      dir_r     <= dir_nxt;
      wr_n_r    <= wr_n_nxt;
      ack_n_r   <= ack_n_nxt;
      en_n_r    <= en_n_nxt;
      oe_r      <= oe_nxt;
      doe_r     <= doe_nxt;
    end
  end

  assign hold_grant       = granted_r;
  assign addr_latch       = ale_r;
  assign mem_io_sel       = sel_r;
  assign mem_io_sel_oe    = oe_r;
  assign write_strobe_n   = wr_n_r;
  assign write_strobe_oe  = oe_r;
  assign int_ack_strobe_n = ack_n_r;
  assign int_ack_oe       = oe_r;
  assign xcvr_direction   = dir_r;
  assign xcvr_dir_oe      = oe_r;
  assign xcvr_enable_n    = en_n_r;
  assign xcvr_enable_oe   = oe_r;
  assign bus_addr         = addr_r;
  assign bus_addr_oe      = oe_r;
  assign bus_data_out     = wdata_r;
  assign bus_data_oe      = doe_r;
  assign queue_state      = qs_r;
  assign q_byte           = qmem[head_r]; // see R18
  assign q_valid          = (cnt_r != '0);
  assign rd_data          = rdat_r;
  assign rd_valid         = rvld_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_addr_phase;
    state_r == mmbc_pkg::ST_T1;
  endsequence

  sequence s_data_phase;
    (state_r == mmbc_pkg::ST_T2) ##1 (state_r == mmbc_pkg::ST_T3);
  endsequence

  latch_in_t1_a: assert property (addr_latch |-> s_addr_phase) // see R5
    else $error("latch pulse outside first state");
  cycle_order_a: assert property (s_addr_phase |=> s_data_phase) // see R22
    else $error("bus cycle states out of order");
  grant_float_a: assert property (hold_grant |-> // see R2
    !(mem_io_sel_oe || write_strobe_oe || xcvr_dir_oe || xcvr_enable_oe))
    else $error("control driven while granted");
  grant_edge_a: assert property ($rose(hold_grant) |-> // see R11
    ($past(state_r) == mmbc_pkg::ST_IDLE ||
     $past(state_r) == mmbc_pkg::ST_T4))
    else $error("grant raised inside a bus cycle");
  write_window_a: assert property (!write_strobe_n |-> // see R3
    (state_r == mmbc_pkg::ST_T2 || state_r == mmbc_pkg::ST_T3 ||
     state_r == mmbc_pkg::ST_TW))
    else $error("write strobe outside its window");
  ack_window_a: assert property (!int_ack_strobe_n |-> // see R4
    (state_r == mmbc_pkg::ST_T2 || state_r == mmbc_pkg::ST_T3 ||
     state_r == mmbc_pkg::ST_TW))
    else $error("acknowledge strobe outside its window");
  queue_bound_a: assert property (cnt_r <= CW'(QB)) // see R15
    else $error("prefetch queue overfilled");
  qstate_first_a: assert property ( // see R21
    (q_take && q_valid && q_first && !flush) |=>
    (queue_state == `MMBC_QS_FIRST))
    else $error("queue state missed first byte");
  empty_show_a: assert property ( // see R18
    (push && (cnt_r == '0) && !flush) |=> q_valid)
    else $error("first byte not shown at once");
endmodule

/* File: verification/mmbc_mem.sv */
// Memory partner: byte at address a reads back as a[7:0]
`timescale 1ns/1ps
module mmbc_mem (
  input  wire logic        clk,  // Clock
  input  wire logic        reset,// Reset
  input  wire logic        ale,  // Latch pulse
  input  wire logic [19:0] addr, // Address
  input  wire logic        en_n, // Transceiver enable
  input  wire logic        dir,  // Direction
  input  wire logic        slow, // Ready low two clocks after latch
  output logic             rdy,  // Ready
  output logic      [15:0] rd    // Read data
);
  logic [7:0] a_r;
  logic [1:0] w_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      a_r <= 8'h00;
      w_r <= 2'h0;
    end else if (ale) begin
      a_r <= {addr[7:1], 1'b0};
      w_r <= slow ? 2'h2 : 2'h0;
    end else if (w_r != 2'h0) begin
      w_r <= w_r - 2'h1;
    end
  end
  assign rdy = (w_r == 2'h0);
  // Released bus shows the inverse, never a stale word
  assign rd = (!en_n && !dir) ? {a_r + 8'h01, a_r} : ~{a_r + 8'h01, a_r};
endmodule

/* File: verification/tb.sv */
// Bench for the bus control and prefetch front end
`timescale 1ns/1ps
`include "mmbc_regs.svh"
module tb;
  logic clk = 1'b0, reset = 1'b1, config_strap = 1'b1, hold_req = 1'b0;
  logic flush = 1'b0, q_take = 1'b0, q_first = 1'b0, op_valid = 1'b0;
  logic slow = 1'b0;
  logic [15:0] flush_seg = 16'h0000, flush_off = 16'h0000;
  logic [15:0] op_seg = 16'h0000, op_off = 16'h0000, op_wdata = 16'h0000;
  logic [2:0]  op_cmd = 3'h0;
  logic bus_ready, hold_grant, addr_latch, mem_io_sel, mem_io_sel_oe;
  logic write_strobe_n, write_strobe_oe, int_ack_strobe_n, int_ack_oe;
  logic xcvr_direction, xcvr_dir_oe, xcvr_enable_n, xcvr_enable_oe;
  logic bus_addr_oe, bus_data_oe, q_valid, op_ready, rd_valid;
  logic [19:0] bus_addr;
  logic [15:0] bus_data_out, bus_data_in, rd_data;
  logic [1:0]  queue_state;
  logic [7:0]  q_byte;
  int num_errors = 0;
  int checks = 0;
  always #25 clk = ~clk;
  mmbc_top uut (.clk, .reset, .config_strap, .hold_req, .bus_ready,
    .hold_grant, .addr_latch, .mem_io_sel, .mem_io_sel_oe, .write_strobe_n,
    .write_strobe_oe, .int_ack_strobe_n, .int_ack_oe, .xcvr_direction,
    .xcvr_dir_oe, .xcvr_enable_n, .xcvr_enable_oe, .bus_addr, .bus_addr_oe,
    .bus_data_out, .bus_data_in, .bus_data_oe, .queue_state, .flush,
    .flush_seg, .flush_off, .q_byte, .q_valid, .q_take, .q_first,
    .op_valid, .op_ready, .op_cmd, .op_seg, .op_off, .op_wdata, .rd_data,
    .rd_valid);
  mmbc_mem mem (.clk, .reset, .ale(addr_latch), .addr(bus_addr),
    .en_n(xcvr_enable_n), .dir(xcvr_direction), .slow, .rdy(bus_ready),
    .rd(bus_data_in));
  task automatic cmp(input string what, input logic [19:0] exp, got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic t_prefetch();
    int n;
    int k;
    flush_seg = 16'h0100;
    flush_off = 16'h0020;
    flush = 1'b1;
    @(negedge clk);
    flush = 1'b0;
    for (n = 0; n < 200 && q_valid !== 1'b1; n++) @(negedge clk);
    cmp("first byte", 20'h20, {12'h0, q_byte});
    repeat (40) @(negedge clk);
    k = 0;
    // A full queue leaves no room for a word, so the bus must stay quiet
    repeat (20) begin
      @(negedge clk);
      k += addr_latch;
    end
    cmp("fetch when full", 20'h0, k[19:0]);
    for (n = 0; n < 6; n++) begin
      cmp("queue byte", 20'(32'h20 + n), {12'h0, q_byte});
      if (n == 1) cmp("qstate", {18'h0, `MMBC_QS_FIRST},
                      {18'h0, queue_state});
      q_take = 1'b1;
      q_first = (n == 0);
      @(negedge clk);
    end
    q_take = 1'b0;
  endtask
  task automatic t_read(input logic s);
    int n;
    slow = s;
    op_cmd = mmbc_pkg::CMD_MEM_RD;
    op_seg = 16'h1000;
    op_off = 16'h0046;
    op_valid = 1'b1;
    for (n = 0; n < 300 && op_ready !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    op_valid = 1'b0;
    for (n = 0; n < 300 && rd_valid !== 1'b1; n++) @(negedge clk);
    cmp("read data", 20'h04746, {4'h0, rd_data});
  endtask
  task automatic t_write();
    int n;
    slow = 1'b0;
    op_cmd = mmbc_pkg::CMD_IO_WR;
    op_off = 16'h0010;
    op_wdata = 16'hA55A;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    for (n = 0; n < 100 && addr_latch !== 1'b1; n++) @(negedge clk);
    cmp("io sel", 20'h0, {19'h0, mem_io_sel});
    @(negedge clk);
    cmp("wr strobe", 20'h0, {19'h0, write_strobe_n});
    cmp("dir tx", 20'h1, {19'h0, xcvr_direction});
    cmp("wr en", 20'h0, {19'h0, xcvr_enable_n});
    cmp("wr data", 20'h0A55A, {4'h0, bus_data_out});
  endtask
  task automatic t_int_ack_strobe_n();
    int n;
    slow = 1'b0;
    op_cmd = mmbc_pkg::CMD_INT_ACK_STROBE_N;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    for (n = 0; n < 100 && addr_latch !== 1'b1; n++) @(negedge clk);
    cmp("ack sel", 20'h0, {19'h0, mem_io_sel});
    @(negedge clk);
    cmp("ack strobe", 20'h0, {19'h0, int_ack_strobe_n});
    @(negedge clk);
    cmp("ack en", 20'h0, {19'h0, xcvr_enable_n});
    cmp("ack dir", 20'h0, {19'h0, xcvr_direction});
  endtask
  task automatic t_hold();
    int n;
    hold_req = 1'b1;
    for (n = 0; n < 100 && hold_grant !== 1'b1; n++) @(negedge clk);
    cmp("grant", 20'h1, {19'h0, hold_grant});
    cmp("sel oe", 20'h0, {19'h0, mem_io_sel_oe});
    cmp("en oe", 20'h0, {19'h0, xcvr_enable_oe});
    cmp("latch", 20'h0, {19'h0, addr_latch});
    hold_req = 1'b0;
    for (n = 0; n < 100 && hold_grant !== 1'b0; n++) @(negedge clk);
    cmp("grant drop", 20'h0, {19'h0, hold_grant});
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    t_prefetch();
    t_read(1'b0);
    t_read(1'b1);
    t_write();
    t_int_ack_strobe_n();
    t_hold();
    wrap_up();
  end
endmodule
